// file: swbm_defines.vh
// shared constants of the single-wire bus master: register map, fields, reset values, timing
`ifndef SWBM_DEFINES_VH
`define SWBM_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SWBM_OFS_CTRL 8'h00
`define SWBM_OFS_STATUS 8'h04
`define SWBM_OFS_DIVIDER 8'h08
`define SWBM_OFS_IRQ_STATUS 8'h0C
`define SWBM_OFS_IRQ_MASK 8'h10

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SWBM_BIT_RESET_PRESENCE 0
`define SWBM_BIT_WRITE_ZERO 1
`define SWBM_BIT_WRITE_ONE_READ 2
`define SWBM_BIT_PRESENCE 0
`define SWBM_BIT_READ_VALUE 1
`define SWBM_BIT_BUSY 2
`define SWBM_BIT_IRQ_DONE 0
`define SWBM_BIT_IRQ_ABSENT 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
// 200 main clocks per microsecond tick at a 200 MHz main clock
`define SWBM_RST_DIVIDER 8'hC8
`define SWBM_RST_IRQ_MASK 2'h0

// ---------------------------------------------------------------
// slot timing in ticks, one tick per microsecond
// ---------------------------------------------------------------
`define SWBM_RESET_LOW_TIME_US 10'h1FF
`define SWBM_PRESENCE_SAMPLE_US 10'h044
`define SWBM_RESET_HIGH_TIME_US 10'h200
`define SWBM_WRITE_ZERO_LOW_TIME_US 10'h064
`define SWBM_SLOT_TIME_US 10'h075
`define SWBM_READ_SLOT_LOW_TIME_US 10'h005
`define SWBM_READ_SAMPLE_US 10'h00D

`endif

// file: swbm_tick.v
// microsecond tick generator: divides the main clock by a programmable ratio
`timescale 1ns/1ps
module swbm_tick (
    input wire aclk,
    input wire aresetn,
    input wire restart,
    input wire [7:0] ratio,
    output reg tick
);

    reg [7:0] count;

    // ---------------------------------------------------------------
    // divider
    // ---------------------------------------------------------------
    // restart aligns the first tick to the start of a sequence, so
    // the first interval is a whole period and not a fraction
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (restart) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (count + 8'h01 >= ratio) begin
            count <= 8'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end

endmodule // swbm_tick

// file: swbm_top.v
// single-wire bus master: slot state machine, pin control and AXI4-Lite register file
//
// Contract
// - run a reset pulse of at least 480 us, then release and look for presence
// - setting the reset request starts the reset; hardware clears it when done
// - presence outcome is latched; one means a slave answered, zero none
// - write-zero slot lasts 117 us with the line held low for 100 us
// - setting the write-zero request starts the slot; cleared when slot finishes
// - write-one and read slots share one waveform: short low, then release
// - setting the write-one/read request starts the slot; cleared when complete
// - at the end of a read slot the sampled level goes to read value; here it is stored at the 13 us sample point
// - reset low 511 us, presence sample at 68 us, reset high recovery 512 us
// - low 100 us for write zero, 5 us for write one/read, sample at 13 us
// - time base divides the main clock by a programmable ratio toward 1 MHz
// - an integer-multiple main clock gives an exact 1 MHz tick
// - main clock must be at least 10 MHz for correct behaviour
// - tick error must stay within 0.0645 relative imprecision
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "swbm_defines.vh"
module swbm_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire line_in,
    output wire line_out,
    output wire line_oe,
    output wire irq
);

    // ---------------------------------------------------------------
    // constants
    // ---------------------------------------------------------------
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RST_LOW = 6'h02;
    localparam [5:0] ST_RST_HIGH = 6'h04;
    localparam [5:0] ST_SLOT = 6'h08;
    localparam [5:0] ST_END = 6'h10;
    localparam [5:0] ST_START = 6'h20;
    localparam [9:0] RESET_LOW_TICKS = `SWBM_RESET_LOW_TIME_US;
    localparam [9:0] PRESENCE_TICKS = `SWBM_PRESENCE_SAMPLE_US;
    localparam [9:0] RESET_HIGH_TICKS = `SWBM_RESET_HIGH_TIME_US;
    localparam [9:0] ZERO_LOW_TICKS = `SWBM_WRITE_ZERO_LOW_TIME_US;
    localparam [9:0] SLOT_TICKS = `SWBM_SLOT_TIME_US;
    localparam [9:0] READ_LOW_TICKS = `SWBM_READ_SLOT_LOW_TIME_US;
    localparam [9:0] SAMPLE_TICKS = `SWBM_READ_SAMPLE_US;
    localparam [7:0] RST_DIVIDER = `SWBM_RST_DIVIDER;
    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [5:0] state;
    reg [9:0] elapsed;
    reg [2:0] request;
    reg presence_status;
    reg read_value_status;
    reg pull_low;
    reg [7:0] divider;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg line_meta;
    reg line_sync;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;
    wire tick;
    wire busy;
    wire do_write;
    wire do_read;
    wire seq_done;
    wire absent_event;
    wire ctrl_write;

    assign busy = |request;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign do_read = s_axi_arvalid & ~s_axi_rvalid;
    assign ctrl_write = do_write & (aw_addr == `SWBM_OFS_CTRL) & w_strb[0];

    // ---------------------------------------------------------------
    // pin
    // ---------------------------------------------------------------
    // open drain: output level is always low, only the enable moves
    assign line_out = 1'b0;
    assign line_oe = pull_low;
    assign irq = |(irq_status & irq_mask);

    // two-flop synchroniser for the line level
    always @(posedge aclk) begin
        if (!aresetn) begin
            line_meta <= 1'b1;
            line_sync <= 1'b1;
        end else begin
            line_meta <= line_in;
            line_sync <= line_meta;
        end
    end

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    // divider must be set for a main clock of 10 MHz or more and chosen
    // so the tick stays within 0.0645 of 1 MHz; hardware cannot check it
    swbm_tick swbm_tick_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(state == ST_START),
        .ratio(divider),
        .tick(tick)
    );

    // ---------------------------------------------------------------
    // slot state machine
    // ---------------------------------------------------------------
    assign seq_done = (state == ST_END);
    assign absent_event = seq_done & request[`SWBM_BIT_RESET_PRESENCE] & ~presence_status;

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            elapsed <= 10'h000;
            pull_low <= 1'b0;
            presence_status <= 1'b0;
            read_value_status <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    pull_low <= 1'b0;
                    elapsed <= 10'h000;
                    if (busy) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    // first falling edge of any sequence
                    pull_low <= 1'b1;
                    elapsed <= 10'h000;
                    if (request[`SWBM_BIT_RESET_PRESENCE]) begin
                        state <= ST_RST_LOW;
                    end else begin
                        state <= ST_SLOT;
                    end
                end
                ST_RST_LOW: begin
                    if (tick) begin
                        elapsed <= elapsed + 10'h001;
                    end
                    if (elapsed >= RESET_LOW_TICKS) begin
                        pull_low <= 1'b0;
                        elapsed <= 10'h000;
                        state <= ST_RST_HIGH;
                    end
                end
                ST_RST_HIGH: begin
                    // slave answers by pulling low after our release
                    if (tick) begin
                        elapsed <= elapsed + 10'h001;
                        if (elapsed + 10'h001 == PRESENCE_TICKS) begin
                            presence_status <= ~line_sync;
                        end
                    end
                    if (elapsed >= RESET_HIGH_TICKS) begin
                        state <= ST_END;
                    end
                end
                ST_SLOT: begin
                    if (tick) begin
                        elapsed <= elapsed + 10'h001;
                        if (elapsed + 10'h001 == SAMPLE_TICKS &&
                            request[`SWBM_BIT_WRITE_ONE_READ]) begin
                            read_value_status <= line_sync;
                        end
                    end
                    if (request[`SWBM_BIT_WRITE_ZERO]) begin
                        pull_low <= (elapsed < ZERO_LOW_TICKS);
                    end else begin
                        pull_low <= (elapsed < READ_LOW_TICKS);
                    end
                    if (elapsed >= SLOT_TICKS) begin
                        pull_low <= 1'b0;
                        state <= ST_END;
                    end
                end
                ST_END: begin
                    pull_low <= 1'b0;
                    state <= ST_IDLE;
                end
                default: begin
                    pull_low <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // request bits
    // ---------------------------------------------------------------
    // a write while busy is dropped; several bits in one write keep only
    // the highest priority one, so a single sequence ever runs
    always @(posedge aclk) begin
        if (!aresetn) begin
            request <= 3'h0;
        end else if (seq_done) begin
            request <= 3'h0;
        end else if (ctrl_write && !busy) begin
            if (w_data[`SWBM_BIT_RESET_PRESENCE]) begin
                request <= 3'h1;
            end else if (w_data[`SWBM_BIT_WRITE_ZERO]) begin
                request <= 3'h2;
            end else if (w_data[`SWBM_BIT_WRITE_ONE_READ]) begin
                request <= 3'h4;
            end
        end
    end

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            divider <= RST_DIVIDER;
            irq_mask <= `SWBM_RST_IRQ_MASK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                case (aw_addr)
                    `SWBM_OFS_CTRL, `SWBM_OFS_STATUS, `SWBM_OFS_IRQ_STATUS: begin
                    end
                    `SWBM_OFS_DIVIDER: begin
                        if (w_strb[0]) begin
                            divider <= w_data[7:0];
                        end
                    end
                    `SWBM_OFS_IRQ_MASK: begin
                        if (w_strb[0]) begin
                            irq_mask <= w_data[1:0];
                        end
                    end
                    default: begin
                        s_axi_bresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = RESP_OKAY;
        case (s_axi_araddr)
            `SWBM_OFS_CTRL: next_rdata[2:0] = request;
            `SWBM_OFS_STATUS: begin
                next_rdata[`SWBM_BIT_PRESENCE] = presence_status;
                next_rdata[`SWBM_BIT_READ_VALUE] = read_value_status;
                next_rdata[`SWBM_BIT_BUSY] = busy;
            end
            `SWBM_OFS_DIVIDER: next_rdata[7:0] = divider;
            `SWBM_OFS_IRQ_STATUS: next_rdata[1:0] = irq_status;
            `SWBM_OFS_IRQ_MASK: next_rdata[1:0] = irq_mask;
            default: next_rresp = RESP_SLVERR;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status
    // ---------------------------------------------------------------
    // cleared by reading it; an event in the same cycle survives the clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= (irq_status &
                ~{2{do_read && (s_axi_araddr == `SWBM_OFS_IRQ_STATUS)}}) |
                {absent_event, seq_done};
        end
    end

endmodule // swbm_top

// file: swbm_asserts.sv
// port-level assertion checker for the single-wire bus master
`timescale 1ns/1ps
module swbm_asserts (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire line_out,
    input wire line_oe
);
    // -----------------------------------------
    // properties
    // -----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // the pin may only be pulled low, never driven high
    property p_drive_low_only; line_out == 1'b0; endproperty
    a_drive_low_only: assert property (p_drive_low_only) else $error("pin driven high");
    // the shortest low pulse is the 5 tick read slot, at least 5 cycles
    property p_oe_min; $rose(line_oe) |-> line_oe [*5]; endproperty
    a_oe_min: assert property (p_oe_min) else $error("low pulse too short");
    // a slot starts two cycles after the control write is performed
    property p_oe_start; $rose(line_oe) |-> $past(s_axi_bvalid, 2); endproperty
    a_oe_start: assert property (p_oe_start) else $error("slot without request");
    property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stand: assert property (p_b_stand) else $error("write response dropped");
    property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data dropped");
    // both halves are held one edge, performed the next, answered after that
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("no write response");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("no read response");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during response");
endmodule // swbm_asserts

bind swbm_top swbm_asserts swbm_asserts_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .line_out(line_out), .line_oe(line_oe));

// file: swbm_slave_model.sv
// behavioural single-wire slave: presence answer and read-zero hold
`timescale 1ns/1ps
module swbm_slave_model #(
    parameter int CYC_PER_US = 2
) (
    input wire aclk,
    input wire line,
    input wire present,
    input wire read_bit,
    output logic pull
);
    int low_len = 0;
    int cnt = 0;
    logic last = 1'b1;
    logic [1:0] mode = 2'd0;
    // presence waits 30 us then holds 120 us; a read zero holds 30 us
    assign pull = (mode == 2'd1 && cnt >= 30 * CYC_PER_US) || mode == 2'd2;
    // edge detection on the shared line, mode 1 presence, mode 2 read zero
    always @(posedge aclk) begin
        last <= line;
        low_len <= (line !== 1'b0) ? 0 : low_len + 1;
        cnt <= cnt + 1;
        if (line === 1'b1 && last === 1'b0 && low_len >= 480*CYC_PER_US && present) begin
            mode <= 2'd1;
            cnt <= 0;
        end else if (line === 1'b0 && last === 1'b1 && mode == 2'd0 && !read_bit) begin
            mode <= 2'd2;
            cnt <= 0;
        end else if ((mode == 2'd1 && cnt >= 150 * CYC_PER_US) ||
                     (mode == 2'd2 && cnt >= 30 * CYC_PER_US)) begin
            mode <= 2'd0;
        end
    end
endmodule // swbm_slave_model

// file: swbm_top_tb.sv
// self-checking testbench of the single-wire bus master
`timescale 1ns/1ps
`include "swbm_defines.vh"
module swbm_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, line_out, line_oe, irq, pull, present, read_bit;
    // open-drain wire with pull-up: low while either party pulls
    wire line = (line_oe ? line_out : 1'b1) & ~pull;
    int mismatches = 0;
    int samples_checked = 0;
    int oe_len = 0;
    int oe_last = 0;
    int oe_pulses = 0;
    time oe_fall_t = 0;

    swbm_top swbm_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rresp(s_axi_rresp),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .line_in(line), .line_out(line_out), .line_oe(line_oe),
        .irq(irq));
    swbm_slave_model #(.CYC_PER_US(2)) swbm_slave_model_i (.aclk(aclk), .line(line),
        .present(present), .read_bit(read_bit), .pull(pull));

    // --------------------------------------
    // clock, pulse monitor, checks
    // --------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // length and count of master low pulses, and when the last one ended
    always @(posedge aclk) begin
        if (line_oe === 1'b1) oe_len <= oe_len + 1;
        else if (oe_len != 0) begin
            oe_last <= oe_len;
            oe_pulses <= oe_pulses + 1;
            oe_fall_t <= $time;
            oe_len <= 0;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // ready is sampled at the falling edge; it only changes at rising edges
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w, b;
        logic [1:0] br;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            br = s_axi_bresp;
            n++;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (b !== 1'b1 && n < 50);
        chk({b, br}, {1'b1, er});
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        int n;
        logic ar, r;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            rr = s_axi_rresp;
            n++;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) chk(r, 1'b1);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] rr;
        axi_read(a, d, rr);
        chk(d, exp);
        chk(rr, er);
    endtask
    // start a slot, optionally poke a refused request, poll until it self clears
    task automatic run(input logic [31:0] c, input int low_us, input int tail_us, input logic poke);
        int p, n;
        logic [31:0] d;
        logic [1:0] rr;
        p = oe_pulses;
        n = 0;
        axi_write(`SWBM_OFS_CTRL, c, 2'h0);
        if (poke) axi_write(`SWBM_OFS_CTRL, 32'h4, 2'h0);
        do begin
            axi_read(`SWBM_OFS_CTRL, d, rr);
            n++;
        end while (d[2:0] !== 3'h0 && n < 2000);
        chk(d, 32'h0);
        chk_in(oe_last, 2 * low_us - 2, 2 * low_us + 2);
        chk_in(($time - oe_fall_t) / 5, 2 * tail_us, 2 * tail_us + 20);
        chk(oe_pulses - p, 32'h1);
    endtask

    // --------------------------------------
    // scenarios
    // --------------------------------------
    task automatic t_regs();
        rd_chk(`SWBM_OFS_DIVIDER, `SWBM_RST_DIVIDER, 2'h0);
        rd_chk(`SWBM_OFS_IRQ_MASK, `SWBM_RST_IRQ_MASK, 2'h0);
        rd_chk(8'h14, 32'h0, 2'h2);
        axi_write(8'h14, 32'h1, 2'h2);
        axi_write(`SWBM_OFS_STATUS, 32'h7, 2'h0);
        rd_chk(`SWBM_OFS_STATUS, 32'h0, 2'h0);
        axi_write(`SWBM_OFS_DIVIDER, 32'h2, 2'h0);
        rd_chk(`SWBM_OFS_DIVIDER, 32'h2, 2'h0);
        axi_write(`SWBM_OFS_IRQ_MASK, 32'h3, 2'h0);
    endtask
    task automatic t_reset(input logic p, input logic [31:0] irqs);
        present <= p;
        run(32'h1, 511, 512, 1'b0);
        rd_chk(`SWBM_OFS_STATUS, {31'h0, p}, 2'h0);
        chk(irq, 1'b1);
        rd_chk(`SWBM_OFS_IRQ_STATUS, irqs, 2'h0);
        chk(irq, 1'b0);
    endtask
    // two request bits at once plus a poke while busy: one write-zero slot only
    task automatic t_wzero();
        axi_write(`SWBM_OFS_IRQ_MASK, 32'h0, 2'h0);
        run(32'h6, 100, 17, 1'b1);
        chk(irq, 1'b0);
        rd_chk(`SWBM_OFS_IRQ_STATUS, 32'h1, 2'h0);
        axi_write(`SWBM_OFS_IRQ_MASK, 32'h3, 2'h0);
    endtask
    task automatic t_read(input logic b);
        read_bit <= b;
        run(32'h4, 5, 112, 1'b0);
        rd_chk(`SWBM_OFS_STATUS, {30'h0, b, 1'b0}, 2'h0);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
        s_axi_wstrb <= 4'hF;
        present <= 1'b1;
        read_bit <= 1'b1;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_reset(1'b1, 32'h1);
        t_reset(1'b0, 32'h3);
        t_wzero();
        t_read(1'b0);
        t_read(1'b1);
        summarize();
    end
    // watchdog: the whole run needs well under 40000 cycles
    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        summarize();
    end
endmodule // swbm_top_tb
